// [hdl/dws_defs.svh]
`ifndef DWS_DEFS_SVH
`define DWS_DEFS_SVH

// ---------------------------------------------------------------
// window watchdog
// ---------------------------------------------------------------
`define DWS_WW_RESET_VAL   7'h7F
`define DWS_WW_ZERO        7'h00
`define DWS_WW_PRESC_LAST  10'h3FF

// ---------------------------------------------------------------
// independent watchdog
// ---------------------------------------------------------------
`define DWS_IW_START       8'h00
`define DWS_IW_END         8'hFF
`define DWS_IW_PRESC_LAST  2'h3
// key codes are arbitrary values
`define DWS_IW_KEY_RELOAD  8'h5A
`define DWS_IW_KEY_START   8'hC3

// ---------------------------------------------------------------
// reset request pulse
// ---------------------------------------------------------------
`define DWS_RST_LAST       4'hF

`endif

// [hdl/dws_indep_wdg.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dws_defs.svh"

module dws_indep_wdg (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// start sources
	input  wire logic       hw_option,
	// key port
	input  wire logic       key_wr,
	input  wire logic [7:0] key_data,
	// slow counting clock
	input  wire logic       low_speed_internal_rc_clock,
	// status
	output var  logic       running,
	output var  logic [7:0] count,
	output var  logic       expire
);

	dws_pkg::dws_state_type state_q;
	logic                   boot_q;
	logic                   rc_prev_q;
	logic [1:0]             presc_q;
	logic [7:0]             count_q;
	logic                   expire_q;
	logic                   rc_rise;
	logic                   tick;
	logic                   reload;
	logic                   sw_start;

	// ---------------------------------------------------------------
	// slow clock edges
	// ---------------------------------------------------------------
	// counting is paced by the rc clock only, never by sys_clk rate
	assign rc_rise  = low_speed_internal_rc_clock & ~rc_prev_q;
	assign tick     = rc_rise && (presc_q == `DWS_IW_PRESC_LAST);
	assign reload   = key_wr && (key_data == `DWS_IW_KEY_RELOAD);
	assign sw_start = key_wr && (key_data == `DWS_IW_KEY_START);

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rc_prev_q <= 1'b0;
			boot_q    <= 1'b0;
		end else begin
			rc_prev_q <= low_speed_internal_rc_clock;
			boot_q    <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// run control
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			state_q <= dws_pkg::dws_st_idle;
		end else begin
			case (state_q)
			dws_pkg::dws_st_idle: begin
				// option sampled on the first edge after reset release
				if ((!boot_q && hw_option) || sw_start) begin
					state_q <= dws_pkg::dws_st_run;
				end
			end
			dws_pkg::dws_st_run: begin
				// no path back to idle: only nrst stops it
				if (tick && !reload && count_q == `DWS_IW_END) begin
					state_q <= dws_pkg::dws_st_fired;
				end
			end
			dws_pkg::dws_st_fired: state_q <= dws_pkg::dws_st_fired;
			default: state_q <= dws_pkg::dws_st_idle;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// counter
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			presc_q <= 2'h0;
			count_q <= `DWS_IW_START;
		end else if (state_q != dws_pkg::dws_st_run) begin
			presc_q <= 2'h0;
			count_q <= `DWS_IW_START;
		end else begin
			if (rc_rise) begin
				presc_q <= presc_q + 2'h1;
			end
			// a key landing on the last tick still rescues the device
			if (reload) begin
				count_q <= `DWS_IW_START;
			end else if (tick && count_q != `DWS_IW_END) begin
				count_q <= count_q + 8'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			expire_q <= 1'b0;
		end else begin
			expire_q <= (state_q == dws_pkg::dws_st_run) && tick && !reload
				&& (count_q == `DWS_IW_END);
		end
	end

	assign running = (state_q != dws_pkg::dws_st_idle);
	assign count   = count_q;
	assign expire  = expire_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_iw_reload_start: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(state_q == dws_pkg::dws_st_run) && reload
		|=> count_q == `DWS_IW_START)
		else $error("key reload did not restart the count");

	chk_iw_end_expire: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		(state_q == dws_pkg::dws_st_run) && tick && !reload
		&& count_q == `DWS_IW_END
		|=> expire_q ##1 !expire_q && state_q == dws_pkg::dws_st_fired)
		else $error("end of count did not expire once");

	chk_iw_rc_paced: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		$past(state_q == dws_pkg::dws_st_run) && $changed(count_q)
		&& count_q != `DWS_IW_START
		|-> $past(tick))
		else $error("count moved without a slow clock tick");

endmodule : dws_indep_wdg
`default_nettype wire

// [hdl/dws_pkg.sv]
package dws_pkg;

	typedef enum logic [1:0] {
		dws_st_idle  = 2'b00,
		dws_st_run   = 2'b01,
		dws_st_fired = 2'b10
	} dws_state_type;

endpackage : dws_pkg

// [hdl/dws_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none
`include "dws_defs.svh"

module dws_supervisor (
	// clock and reset
	input  wire logic       sys_clk,
	input  wire logic       nrst,
	// non-volatile option levels
	input  wire logic       ww_hw_option,
	input  wire logic       iw_hw_option,
	// window watchdog software port
	input  wire logic       ww_start,
	input  wire logic       ww_refresh,
	input  wire logic [6:0] ww_refresh_value,
	input  wire logic [6:0] ww_window,
	// independent watchdog software port
	input  wire logic       iw_key_wr,
	input  wire logic [7:0] iw_key_data,
	input  wire logic       low_speed_internal_rc_clock,
	// status
	output var  logic       ww_running,
	output var  logic [6:0] ww_count,
	output var  logic       iw_running,
	output var  logic [7:0] iw_count,
	// reset request
	output var  logic       dev_reset_req,
	output var  logic       reset_cause_ww,
	output var  logic       reset_cause_iw
);

	// ---------------------------------------------------------------
	// declarations
	// ---------------------------------------------------------------
	dws_pkg::dws_state_type ww_state_q;
	logic                   boot_q;
	logic [9:0]             ww_presc_q;
	logic [6:0]             ww_count_q;
	logic                   ww_fire_q;
	logic                   ww_tick;
	logic                   ww_active;
	logic                   ww_early;
	logic                   ww_late;
	logic                   iw_expire;
	logic                   rst_act_q;
	logic [3:0]             rst_cnt_q;
	logic                   cause_ww_q;
	logic                   cause_iw_q;

	// ---------------------------------------------------------------
	// independent watchdog
	// ---------------------------------------------------------------
	dws_indep_wdg u_indep (
		.sys_clk                     (sys_clk),
		.nrst                        (nrst),
		.hw_option                   (iw_hw_option),
		.key_wr                      (iw_key_wr),
		.key_data                    (iw_key_data),
		.low_speed_internal_rc_clock (low_speed_internal_rc_clock),
		.running                     (iw_running),
		.count                       (iw_count),
		.expire                      (iw_expire)
	);

	// ---------------------------------------------------------------
	// window watchdog control
	// ---------------------------------------------------------------
	assign ww_active = (ww_state_q == dws_pkg::dws_st_run);
	assign ww_tick   = ww_active && (ww_presc_q == `DWS_WW_PRESC_LAST);
	// counter still above the window value: refresh came too soon
	assign ww_early  = ww_active && ww_refresh
		&& (ww_count_q > ww_window);
	// counter ran out with no refresh
	assign ww_late   = ww_active && !ww_refresh && ww_tick
		&& (ww_count_q == `DWS_WW_ZERO);

	// option level is caught by a clocked process after reset release
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			boot_q <= 1'b0;
		end else begin
			boot_q <= 1'b1;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ww_state_q <= dws_pkg::dws_st_idle;
		end else begin
			case (ww_state_q)
			dws_pkg::dws_st_idle: begin
				if ((!boot_q && ww_hw_option) || ww_start) begin
					ww_state_q <= dws_pkg::dws_st_run;
				end
			end
			dws_pkg::dws_st_run: begin
				// the only exits lead to fired; software has no stop
				if (ww_early || ww_late) begin
					ww_state_q <= dws_pkg::dws_st_fired;
				end
			end
			dws_pkg::dws_st_fired: ww_state_q <= dws_pkg::dws_st_fired;
			default: ww_state_q <= dws_pkg::dws_st_idle;
			endcase
		end
	end

	// ---------------------------------------------------------------
	// window watchdog counter
	// ---------------------------------------------------------------
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ww_presc_q <= 10'h000;
		end else if (!ww_active || ww_refresh) begin
			// refresh restarts the prescaler so each period is whole
			ww_presc_q <= 10'h000;
		end else begin
			ww_presc_q <= ww_presc_q + 10'h001;
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ww_count_q <= `DWS_WW_RESET_VAL;
		end else if (ww_active) begin
			// refresh inside the window beats a simultaneous tick
			if (ww_refresh && !ww_early) begin
				ww_count_q <= ww_refresh_value;
			end else if (ww_tick && ww_count_q != `DWS_WW_ZERO) begin
				ww_count_q <= ww_count_q - 7'h01;
			end
		end
	end

	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			ww_fire_q <= 1'b0;
		end else begin
			ww_fire_q <= ww_early || ww_late;
		end
	end

	// ---------------------------------------------------------------
	// device reset request
	// ---------------------------------------------------------------
	// the pulse is fixed length; the system is expected to pull nrst
	// from it, which clears every watchdog back to stopped
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			rst_act_q <= 1'b0;
			rst_cnt_q <= 4'h0;
		end else if (!rst_act_q) begin
			if (ww_fire_q || iw_expire) begin
				rst_act_q <= 1'b1;
				rst_cnt_q <= 4'h0;
			end
		end else if (rst_cnt_q != `DWS_RST_LAST) begin
			rst_cnt_q <= rst_cnt_q + 4'h1;
		end else begin
			rst_act_q <= 1'b0;
		end
	end

	// cause flags stay until nrst so software can read why it restarted
	always_ff @(posedge sys_clk or negedge nrst) begin
		if (!nrst) begin
			cause_ww_q <= 1'b0;
			cause_iw_q <= 1'b0;
		end else begin
			if (ww_fire_q) begin
				cause_ww_q <= 1'b1;
			end
			if (iw_expire) begin
				cause_iw_q <= 1'b1;
			end
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign ww_running     = (ww_state_q != dws_pkg::dws_st_idle);
	assign ww_count       = ww_count_q;
	assign dev_reset_req  = rst_act_q;
	assign reset_cause_ww = cause_ww_q;
	assign reset_cause_iw = cause_iw_q;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	chk_ww_option_start: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!boot_q && ww_hw_option |=> ww_running)
		else $error("window option did not start the watchdog");

	chk_ww_sw_start: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ww_start |=> ww_running)
		else $error("software start was not taken");

	chk_iw_option_start: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		!boot_q && iw_hw_option |=> iw_running)
		else $error("independent option did not start the watchdog");

	chk_ww_no_stop: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ww_running |=> ww_running [*8])
		else $error("window watchdog stopped without reset");

	chk_iw_no_stop: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		iw_running |=> iw_running [*8])
		else $error("independent watchdog stopped without reset");

	chk_ww_early_reset: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ww_active && ww_refresh && (ww_count_q > ww_window) && !rst_act_q
		&& !iw_expire
		|-> ##2 dev_reset_req && reset_cause_ww)
		else $error("early refresh gave no reset");

	chk_ww_good_refresh: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		ww_active && ww_refresh && (ww_count_q <= ww_window)
		|=> ww_count_q == $past(ww_refresh_value) && !ww_fire_q)
		else $error("refresh inside the window misbehaved");

	chk_iw_expire_reset: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		iw_expire && !rst_act_q |=> dev_reset_req && reset_cause_iw
		##15 dev_reset_req ##1 !dev_reset_req)
		else $error("independent expiry reset pulse wrong");

	chk_iw_key_reload: assert property (
		@(posedge sys_clk) disable iff (!nrst)
		iw_running && !iw_expire && iw_key_wr
		&& iw_key_data == `DWS_IW_KEY_RELOAD && iw_count != `DWS_IW_START
		|=> iw_count == `DWS_IW_START)
		else $error("key write did not reload the counter");

endmodule : dws_supervisor
`default_nettype wire

// [test/tb_dws_supervisor.sv]
`timescale 1ns/100ps
`default_nettype none

module tb_dws_supervisor;

	// ---------------------------------------------------------------
	// design ports
	// ---------------------------------------------------------------
	logic       sys_clk = 1'b0;
	logic       nrst;
	logic       ww_hw_option;
	logic       iw_hw_option;
	logic       ww_start;
	logic       ww_refresh;
	logic [6:0] ww_refresh_value;
	logic [6:0] ww_window;
	logic       iw_key_wr;
	logic [7:0] iw_key_data;
	logic       low_speed_internal_rc_clock = 1'b0;
	logic       ww_running;
	logic [6:0] ww_count;
	logic       iw_running;
	logic [7:0] iw_count;
	logic       dev_reset_req;
	logic       reset_cause_ww;
	logic       reset_cause_iw;

	// ---------------------------------------------------------------
	// bench state
	// ---------------------------------------------------------------
	typedef struct packed {
		logic [7:0] key;
		logic       run;
	} dws_row_type;

	// wrong and reload keys before start must not start the timer
	dws_row_type rows [5] = '{'{8'h00, 1'b0}, '{8'h5A, 1'b0},
		'{8'hC2, 1'b0}, '{8'hC3, 1'b1}, '{8'h00, 1'b1}};
	int   err_count;
	int   checked;
	logic rc_run;

	dws_supervisor u_dut (
		.sys_clk, .nrst, .ww_hw_option, .iw_hw_option, .ww_start,
		.ww_refresh, .ww_refresh_value, .ww_window, .iw_key_wr,
		.iw_key_data, .low_speed_internal_rc_clock, .ww_running,
		.ww_count, .iw_running, .iw_count, .dev_reset_req,
		.reset_cause_ww, .reset_cause_iw
	);

	always #50 sys_clk = ~sys_clk;

	// rc clock is kept fast so a full independent count stays short
	// run flag taken at the edge, where it is settled, so the first
	// toggle never races the stimulus that sets it
	always @(posedge sys_clk) begin
		if (rc_run) begin
			#10;
			low_speed_internal_rc_clock = ~low_speed_internal_rc_clock;
		end
	end

	// ---------------------------------------------------------------
	// tasks
	// ---------------------------------------------------------------
	task stop_test;
		if (err_count == 0 && checked > 0) begin
			$display("Simulation passed");
		end else begin
			$display("Simulation failed");
		end
		$finish;
	endtask : stop_test

	task check(input logic [7:0] seen, input logic [7:0] exp);
		checked++;
		if (seen !== exp) begin
			err_count++;
			$display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask : check

	task cyc(input int n);
		repeat (n) begin
			@(posedge sys_clk);
			#10;
		end
	endtask : cyc

	task do_reset(input logic wo, input logic io);
		nrst = 1'b0;
		rc_run = 1'b0;
		ww_hw_option = wo;
		iw_hw_option = io;
		cyc(20);
		check(dev_reset_req, 8'h00);
		check({reset_cause_ww, reset_cause_iw}, 8'h00);
		check({ww_running, iw_running}, 8'h00);
		check(iw_count, 8'h00);
		check(ww_count, 8'h7F);
		nrst = 1'b1;
		cyc(1);
	endtask : do_reset

	task key(input logic [7:0] k);
		iw_key_data = k;
		iw_key_wr = 1'b1;
		cyc(1);
		iw_key_wr = 1'b0;
	endtask : key

	task refresh(input logic [6:0] v, input logic [6:0] w);
		ww_refresh_value = v;
		ww_window = w;
		ww_refresh = 1'b1;
		cyc(1);
		ww_refresh = 1'b0;
	endtask : refresh

	// bounded wait for the reset request; running out counts a mismatch
	task wait_req(output int n);
		n = 0;
		while (dev_reset_req !== 1'b1 && n <= 3000) begin
			cyc(1);
			n++;
		end
		if (n > 3000) begin
			err_count++;
		end
	endtask : wait_req

	// ---------------------------------------------------------------
	// main sequence
	// ---------------------------------------------------------------
	initial begin
		int         n;
		logic [7:0] c0;
		sys_clk = 1'b0;
		{ww_start, ww_refresh, iw_key_wr} = 3'b000;
		ww_refresh_value = 7'h00;
		ww_window = 7'h7F;
		iw_key_data = 8'h00;
		low_speed_internal_rc_clock = 1'b0;
		err_count = 0;
		checked = 0;
		do_reset(1'b0, 1'b0);
		check({ww_running, iw_running}, 8'h00);
		refresh(7'h10, 7'h7F);
		check(ww_count, 8'h7F);
		for (int i = 0; i < 5; i++) begin
			key(rows[i].key);
			check(iw_running, rows[i].run);
			// an edge passes so the strobe is not raised again at once
			cyc(1);
		end
		// window watchdog: good refreshes, boundary, then an early one
		ww_start = 1'b1;
		cyc(1);
		ww_start = 1'b0;
		check(ww_running, 8'h01);
		refresh(7'h40, 7'h7F);
		check(ww_count, 8'h40);
		cyc(1);
		refresh(7'h30, 7'h40);
		check(ww_count, 8'h30);
		cyc(2);
		check(dev_reset_req, 8'h00);
		refresh(7'h20, 7'h2F);
		check(dev_reset_req, 8'h00);
		cyc(1);
		check({dev_reset_req, reset_cause_ww}, 8'h03);
		for (int i = 0; i < 15; i++) begin
			cyc(1);
			check(dev_reset_req, 8'h01);
		end
		cyc(1);
		check(dev_reset_req, 8'h00);
		refresh(7'h11, 7'h7F);
		cyc(3);
		check({dev_reset_req, ww_running}, 8'h01);
		check(ww_count == 7'h11, 8'h00);
		check(reset_cause_iw, 8'h00);
		// independent watchdog started by its option
		do_reset(1'b0, 1'b1);
		check({ww_running, iw_running}, 8'h01);
		cyc(100);
		check(iw_count, 8'h00);
		rc_run = 1'b1;
		cyc(40);
		rc_run = 1'b0;
		cyc(4);
		c0 = iw_count;
		check(c0 >= 8'h04 && c0 <= 8'h06, 8'h01);
		key(8'h5A);
		check(iw_count, 8'h00);
		rc_run = 1'b1;
		wait_req(n);
		check(n >= 2030 && n <= 2070, 8'h01);
		check({reset_cause_iw, reset_cause_ww}, 8'h02);
		check(iw_running, 8'h01);
		// both started by options; the window one is then left to run out
		do_reset(1'b1, 1'b1);
		check({ww_running, iw_running}, 8'h03);
		refresh(7'h01, 7'h7F);
		check(ww_count, 8'h01);
		wait_req(n);
		// two whole prescaler periods: one to reach zero, one to run out
		check(n >= 2045 && n <= 2053, 8'h01);
		check({reset_cause_ww, reset_cause_iw}, 8'h02);
		check(ww_count, 8'h00);
		// no slow clock edges, so the independent count never moved
		check(iw_count, 8'h00);
		stop_test();
	end

endmodule : tb_dws_supervisor

`default_nettype wire
